// >>> cstc_defs.svh
// Purpose: Constants for the charger safety timer control block.
// Assumes: Included by the timer block, the pack model and the bench.
// Notes:   Offsets are byte addresses on a 32-bit AXI4-Lite bus.
// What this block does
// - With neither adapter nor USB input present the charger sits in off state.
// - A pre-charge safety timer runs through the whole pre-conditioning phase.
// - Pre-charge timeout is one tenth of the fast-charge timeout.
// - Suspend by run bit low or pack temperature fault freezes both timers.
// - Pre-charge expiry below the pre-charge threshold flags a fault, charger off.
// - A floating timer pin selects the internal timebase for the timeouts.
// - The fast-charge timer starts when pre-conditioning ends.
// - Fast-charge expiry without termination flags a fault, charger off.
// - Fast-charge timer held in reset while timer pin floats or termination is off.
// - Fault above recharge level waits for battery to drop, then restarts.
// - Fault below recharge level enables removal pull-up until battery rises.
// - A new cycle clears timers and faults; enable toggles or power cycling start one.
// - Undervoltage lockout clears every timer and every timer fault.
// - Pre-charge timer slows while either loop is active with a depleted battery.
// - Fast timer slows only with a loop active and battery below recharge level.
// - Slowing stretches the tick by reference over current-set level.
// - A stretched tick never exceeds twice the programmed tick.
// - Added time is the stretched share of loop-active time, at most half of it, capped at twice the timeout.
// - The input-limit loop status is reported while it holds the output up.
// - Supplement mode is reported when the output keeps falling past the loop.
`ifndef CSTC_DEFS_SVH
`define CSTC_DEFS_SVH
`define CSTC_ADDR_CTRL  4'h0
`define CSTC_ADDR_TDIV  4'h4
`define CSTC_ADDR_STAT  4'h8
`define CSTC_CTRL_RST   5'h03
`define CSTC_TDIV_RST   16'h0FA0
`define CSTC_TDIV_INT   16'h0FA0
`define CSTC_FAST_TICKS 24'h00EA60
`define CSTC_PRE_DIV    24'h00000A
`define CSTC_REF_FAST   8'hC8
`define CSTC_REF_PRE    8'h14
`define CSTC_RESP_OK    2'h0
`define CSTC_RESP_ERR   2'h2
`endif

// >>> cstc_pkg.sv
// Purpose: Types shared by the charger safety timer control block.
// Assumes: Nothing beyond the defines header.
// Notes:   States follow a Gray path off, pre, fast, done, fault.
package cstc_pkg;
	typedef enum logic [2:0] {
		ST_OFF   = 3'h0,
		ST_PRE   = 3'h1,
		ST_FAST  = 3'h3,
		ST_DONE  = 3'h2,
		ST_FAULT = 3'h6
	} cstc_state_type;
	typedef struct packed {
		logic ac_det;
		logic usb_det;
		logic uvlo;
		logic tmr_float;
		logic above_prechg;
		logic above_rch;
		logic term_det;
		logic temp_fault;
		logic thermal_loop;
		logic input_limit_loop;
		logic supplement;
	} cstc_pins_type;
	typedef struct packed {
		logic [1:0] iset_scale;
		logic term_off;
		logic charge_run;
		logic charge_enable;
	} cstc_ctrl_type;
endpackage : cstc_pkg

// >>> cstc_timer_ctl.sv
// Purpose: Charger safety timers, dynamic slowdown, fault recovery, AXI4-Lite registers.
// Assumes: Comparator pins are asynchronous; iset_code changes slowly against the clock.
// Notes:   Registers: control at 0x0, tick divisor at 0x4, status at 0x8.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cstc_defs.svh"
module cstc_timer_ctl
	import cstc_pkg::*;
#(
	parameter logic [23:0] FAST_TICKS = `CSTC_FAST_TICKS
) (
	// Clock and reset.
	input  wire logic                core_clk,
	input  wire logic                rst,
	// AXI4-Lite slave.
	input  wire logic [3:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [3:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Analog comparator pins.
	input  wire cstc_pins_type       pins,
	input  wire logic [7:0]          iset_code,
	// Charger controls.
	output logic                     charge_on,
	output logic                     removal_pullup,
	output logic                     timer_fault
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	cstc_pins_type pins_m_r;
	cstc_pins_type p;
	logic [7:0]    iset_m_r;
	logic [7:0]    iset_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pins_m_r <= '0;
			p        <= '0;
			iset_m_r <= 8'h00;
			iset_r   <= 8'h00;
		end else begin
			pins_m_r <= pins;
			p        <= pins_m_r;
			iset_m_r <= iset_code;
			iset_r   <= iset_m_r;
		end
	end

	// ****************************************
	// Register bus
	// ****************************************
	cstc_ctrl_type  ctrl_r;
	logic [15:0]    tdiv_r;
	cstc_state_type state_r;
	logic           wr_go;
	logic           rd_go;
	logic           wr_hs;
	logic           rd_hs;
	// Ready pulses one cycle after the request; the store and the response wait for the
	// handshake edge, so bvalid and rvalid never run ahead of the address transfer.
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign wr_hs = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	assign rd_hs = s_axi_arready && s_axi_arvalid;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CSTC_RESP_OK;
			ctrl_r        <= `CSTC_CTRL_RST;
			tdiv_r        <= `CSTC_TDIV_RST;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_hs) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `CSTC_RESP_OK;
				unique case (s_axi_awaddr)
					`CSTC_ADDR_CTRL: begin
						if (s_axi_wstrb[0]) begin
							ctrl_r <= s_axi_wdata[4:0];
						end
					end
					`CSTC_ADDR_TDIV: begin
						if (s_axi_wstrb[0]) begin
							tdiv_r[7:0] <= s_axi_wdata[7:0];
						end
						if (s_axi_wstrb[1]) begin
							tdiv_r[15:8] <= s_axi_wdata[15:8];
						end
					end
					`CSTC_ADDR_STAT: ;
					default: s_axi_bresp <= `CSTC_RESP_ERR;
				endcase
			end
		end
	end

	logic [31:0] stat_word;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `CSTC_RESP_OK;
		end else begin
			s_axi_arready <= rd_go;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `CSTC_RESP_OK;
				unique case (s_axi_araddr)
					`CSTC_ADDR_CTRL: s_axi_rdata <= {27'h0, ctrl_r};
					`CSTC_ADDR_TDIV: s_axi_rdata <= {16'h0, tdiv_r};
					`CSTC_ADDR_STAT: s_axi_rdata <= stat_word;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `CSTC_RESP_ERR;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Timebase
	// ****************************************
	// The floating timer pin swaps in the internal divisor, so pre-charge timing survives it.
	// Term-off hands the timebase to the internal divisor too, since the fast timer is parked then.
	logic [15:0] div_r;
	logic        tick_r;
	logic [15:0] div_lim;
	assign div_lim = (p.tmr_float || ctrl_r.term_off) ? `CSTC_TDIV_INT : tdiv_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r >= div_lim);
			div_r  <= (div_r >= div_lim) ? 16'h0000 : div_r + 16'h0001;
		end
	end

	// ****************************************
	// Cycle control
	// ****************************************
	logic power_in;
	logic suspend;
	logic was_power_r;
	logic ce_d_r;
	logic run_d_r;
	logic restart;
	logic expired;
	logic [23:0] cnt_r;
	logic [23:0] limit;
	assign power_in = p.ac_det || p.usb_det;
	assign suspend  = !ctrl_r.charge_run || p.temp_fault;
	assign restart  = (ctrl_r.charge_enable && !ce_d_r) || (ctrl_r.charge_run && !run_d_r)
		|| (power_in && !was_power_r);
	assign limit    = (state_r == ST_PRE) ? FAST_TICKS / `CSTC_PRE_DIV : FAST_TICKS;
	assign expired  = (cnt_r >= limit);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			was_power_r <= 1'b0;
			ce_d_r      <= 1'b0;
			run_d_r     <= 1'b0;
		end else begin
			was_power_r <= power_in;
			ce_d_r      <= ctrl_r.charge_enable;
			run_d_r     <= ctrl_r.charge_run;
		end
	end

	// Off and restart outrank the phase logic, so an expiry in the same cycle as a restart is dropped.
	logic pullup_r;
	logic fault_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r  <= ST_OFF;
			pullup_r <= 1'b0;
			fault_r  <= 1'b0;
		end else if (!power_in || p.uvlo || !ctrl_r.charge_enable) begin
			state_r  <= ST_OFF;
			pullup_r <= 1'b0;
			fault_r  <= 1'b0;
		end else if (restart) begin
			state_r  <= p.above_prechg ? ST_FAST : ST_PRE;
			pullup_r <= 1'b0;
			fault_r  <= 1'b0;
		end else begin
			unique case (state_r)
				ST_OFF: state_r <= p.above_prechg ? ST_FAST : ST_PRE;
				ST_PRE: begin
					if (p.above_prechg) begin
						state_r <= ST_FAST;
					end else if (expired) begin
						state_r  <= ST_FAULT;
						fault_r  <= 1'b1;
						pullup_r <= !p.above_rch;
					end
				end
				ST_FAST: begin
					// Termination is ignored while a loop cuts current or the battery supplements.
					if (p.term_det && !ctrl_r.term_off && !p.thermal_loop && !p.input_limit_loop
						&& !p.supplement) begin
						state_r <= ST_DONE;
					end else if (expired && !p.tmr_float && !ctrl_r.term_off) begin
						state_r  <= ST_FAULT;
						fault_r  <= 1'b1;
						pullup_r <= !p.above_rch;
					end
				end
				ST_DONE: begin
					if (!p.above_rch || ctrl_r.term_off) begin
						state_r <= p.above_prechg ? ST_FAST : ST_PRE;
					end
				end
				ST_FAULT: begin
					if (pullup_r) begin
						pullup_r <= !p.above_rch;
					end else if (!p.above_rch) begin
						state_r <= p.above_prechg ? ST_FAST : ST_PRE;
						fault_r <= 1'b0;
					end
				end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	// ****************************************
	// Safety timer with dynamic slowdown
	// ****************************************
	// A fractional accumulator turns ref/iset stretching into whole ticks without a divider.
	logic        slow;
	logic [7:0]  ref_code;
	logic [7:0]  step;
	logic [8:0]  acc_sum;
	logic [7:0]  acc_r;
	logic [25:0] added_r;
	logic        phase_hold;
	logic        timing;
	assign ref_code = (state_r == ST_PRE) ? `CSTC_REF_PRE : `CSTC_REF_FAST;
	assign slow = (state_r == ST_PRE) ? (p.thermal_loop || p.input_limit_loop)
		: ((p.thermal_loop || p.input_limit_loop) && !p.above_rch);
	always_comb begin
		step = ref_code;
		if (slow && (added_r < {limit, 1'b0})) begin
			step = (iset_r < {1'b0, ref_code[7:1]}) ? {1'b0, ref_code[7:1]} : iset_r;
			if (step > ref_code) begin
				step = ref_code;
			end
		end
	end
	assign acc_sum    = {1'b0, acc_r} + {1'b0, step};
	assign timing     = (state_r == ST_PRE) || (state_r == ST_FAST);
	assign phase_hold = (state_r == ST_FAST) && (p.tmr_float || ctrl_r.term_off);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r   <= 24'h000000;
			acc_r   <= 8'h00;
			added_r <= 26'h0000000;
		end else if (!timing || restart || phase_hold || p.uvlo || !power_in
			|| (state_r == ST_PRE && p.above_prechg)) begin
			cnt_r   <= 24'h000000;
			acc_r   <= 8'h00;
			added_r <= 26'h0000000;
		end else if (tick_r && !suspend) begin
			if (acc_sum >= {1'b0, ref_code}) begin
				acc_r <= 8'(acc_sum - {1'b0, ref_code});
				cnt_r <= cnt_r + 24'h000001;
			end else begin
				acc_r <= acc_sum[7:0];
				added_r <= added_r + 26'h0000001;
			end
		end
	end

	// ****************************************
	// Outputs and status
	// ****************************************
	// Outputs are registered copies, so each lags its internal state by one edge.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			charge_on      <= 1'b0;
			removal_pullup <= 1'b0;
			timer_fault    <= 1'b0;
		end else begin
			charge_on      <= timing && !suspend;
			removal_pullup <= pullup_r;
			timer_fault    <= fault_r;
		end
	end
	// Status bits: 2:0 state, 3 fault, 4 pull-up, 5 loop active, 6 supplement, 7 ac, 8 usb.
	assign stat_word = {23'h0, p.usb_det, p.ac_det, p.supplement,
		p.thermal_loop || p.input_limit_loop, pullup_r, fault_r, state_r};

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_off_no_input: assert property (!power_in |=> state_r == ST_OFF)
		else $error("charger not off without input");
	a_uvlo_clears: assert property (p.uvlo |=> cnt_r == 24'h0 && !fault_r)
		else $error("uvlo did not clear timers");
	a_suspend_hold: assert property (suspend && timing && !restart && $stable(state_r)
		&& !p.uvlo && power_in && !phase_hold && !(state_r == ST_PRE && p.above_prechg)
		|=> $stable(cnt_r))
		else $error("timer moved in suspend");
	a_pre_fault: assert property (state_r == ST_PRE && expired && !p.above_prechg && power_in
		&& !p.uvlo && ctrl_r.charge_enable && !restart |=> fault_r ##1 timer_fault)
		else $error("pre-charge expiry missed");
	a_fast_hold: assert property (state_r == ST_FAST && p.tmr_float |=> cnt_r == 24'h0)
		else $error("fast timer ran with float pin");
	a_pull_below: assert property ($rose(fault_r) && !$past(p.above_rch) |-> pullup_r)
		else $error("pull-up not set");
	a_restart_clr: assert property (restart |=> !fault_r && cnt_r == 24'h0)
		else $error("restart left fault");
	a_step_floor: assert property (timing |-> step >= {1'b0, ref_code[7:1]})
		else $error("tick stretched past double");
	a_pre_limit: assert property (state_r == ST_PRE |-> limit == FAST_TICKS / `CSTC_PRE_DIV)
		else $error("pre limit wrong");
	a_no_slow_fast: assert property (state_r == ST_FAST && p.above_rch |-> step == ref_code)
		else $error("fast timer slowed above recharge");
	// The transition checks below leave out the off path, and a_fast_fault the restart path too, since both take priority over the phases.
	a_fault_off: assert property (state_r == ST_FAULT |=> !charge_on)
		else $error("charger on during fault");
	a_off_output: assert property (!power_in |-> ##2 !charge_on)
		else $error("charger on without input");
	a_charge_run: assert property ((state_r == ST_PRE || state_r == ST_FAST) && !suspend |=> charge_on)
		else $error("charger not running in a timed phase");
	a_pre_to_fast: assert property (state_r == ST_PRE && p.above_prechg && power_in && !p.uvlo
		&& ctrl_r.charge_enable |=> state_r == ST_FAST && cnt_r == 24'h000000)
		else $error("fast timer did not start from zero");
	a_fast_fault: assert property (state_r == ST_FAST && expired && !p.tmr_float && !ctrl_r.term_off
		&& !p.term_det && power_in && !p.uvlo && ctrl_r.charge_enable && !restart |=> fault_r)
		else $error("fast-charge expiry missed");
	a_fault_exit: assert property (state_r == ST_FAULT && !pullup_r && !p.above_rch && power_in
		&& !p.uvlo && ctrl_r.charge_enable |=> !fault_r && state_r != ST_FAULT)
		else $error("fault not cleared below recharge");
	a_added_cap: assert property (timing |-> added_r <= {1'b0, limit, 1'b0})
		else $error("added time above cap");
	a_tick_gap: assert property (tick_r && div_lim != 16'h0000 |=> !tick_r)
		else $error("timebase ticked twice in a row");
	a_pullup_fault: assert property (pullup_r |-> state_r == ST_FAULT)
		else $error("pull-up on outside fault");
	c_fault: cover property (state_r == ST_FAST ##1 state_r == ST_FAULT);
	c_recover: cover property (state_r == ST_FAULT ##1 state_r == ST_PRE);
	c_slow: cover property (timing && slow && tick_r);
	c_done: cover property (state_r == ST_DONE);
	c_suspend: cover property (timing && suspend ##1 timing && !suspend);
endmodule : cstc_timer_ctl

// >>> cstc_pack_model.sv
// Purpose: Battery pack and input supply model facing the charger timer block.
// Assumes: The bench sets supply, battery level and loop states as plain levels.
// Notes:   A removed pack reads as charged only while the removal pull-up is on.
`timescale 1ns/1ps
`include "cstc_defs.svh"
module cstc_pack_model
	import cstc_pkg::*;
(
	// Bench controls.
	input  wire logic       ac_on,
	input  wire logic       usb_on,
	input  wire logic [1:0] vbat,
	input  wire logic       present,
	input  wire logic [6:0] misc,
	input  wire logic [7:0] loop_iset,
	// Device side.
	input  wire logic       removal_pullup,
	output cstc_pins_type   pins,
	output logic [7:0]      iset_code
);
	// ****************************************
	// Pack levels and current-set pin
	// ****************************************
	logic pre_ok;
	logic rch_ok;
	// With no pack the terminal floats up to the output rail through the pull-up only.
	assign pre_ok = present ? (vbat != 2'h0) : removal_pullup;
	assign rch_ok = present ? (vbat == 2'h2) : removal_pullup;
	always_comb begin
		pins                  = '0;
		pins.ac_det           = ac_on;
		pins.usb_det          = usb_on;
		pins.uvlo             = misc[0];
		pins.tmr_float        = misc[1];
		pins.term_det         = misc[2];
		pins.temp_fault       = misc[3];
		pins.thermal_loop     = misc[4];
		pins.input_limit_loop = misc[5];
		pins.supplement       = misc[6];
		pins.above_prechg     = pre_ok;
		pins.above_rch        = rch_ok;
	end
	// A loop pulls the current-set level below its reference; otherwise it sits on it.
	assign iset_code = (misc[4] | misc[5]) ? loop_iset : (pre_ok ? `CSTC_REF_FAST : `CSTC_REF_PRE);
endmodule : cstc_pack_model

// >>> tb_charger_safety_timer_control.sv
// Purpose: Self-checking bench for the charger safety timer control block.
// Assumes: Fast limit of 40 ticks and a tick every 3 cycles, so pre limit is 12 cycles.
// Notes:   Pin changes need about four edges to reach the outputs.
`timescale 1ns/1ps
`include "cstc_defs.svh"
module tb_charger_safety_timer_control
	import cstc_pkg::*;
();
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, vbat;
	logic ac_on, usb_on, present, charge_on, removal_pullup, timer_fault;
	logic [6:0] misc;
	logic [7:0] loop_iset, iset_code;
	cstc_pins_type pins;
	int fail_count = 0;
	int checked = 0;

	always #2.5 core_clk = ~core_clk;

	cstc_timer_ctl #(.FAST_TICKS(24'h000028)) uut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .iset_code, .charge_on, .removal_pullup,
		.timer_fault);
	cstc_pack_model pack (.ac_on, .usb_on, .vbat, .present, .misc, .loop_iset, .removal_pullup,
		.pins, .iset_code);

	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [3:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr

	task automatic st(input string what, input logic [2:0] e);
		rdr(`CSTC_ADDR_STAT);
		chk(what, rd[2:0], e);
	endtask : st

	// Toggling the enable bit starts a fresh charge cycle.
	task automatic restart(input logic [31:0] v);
		wr(`CSTC_ADDR_CTRL, v & 32'hFFFFFFFE);
		wr(`CSTC_ADDR_CTRL, v);
	endtask : restart

	task automatic fault_after(input string what, input int lo, input int hi);
		int k;
		k = 0;
		while (timer_fault !== 1'b1 && k <= hi) begin
			@(posedge core_clk);
			k++;
		end
		chk(what, 32'(k >= lo && k <= hi), 32'h1);
	endtask : fault_after

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		#150000;
		fail_count++;
		give_verdict();
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		{ac_on, usb_on, vbat, misc} = '0;
		present = 1'b1;
		loop_iset = 8'h05;
		cyc(6);
		rst <= 1'b0;
		rdr(`CSTC_ADDR_CTRL);
		chk("ctrl reset", rd, 32'h00000003);
		rdr(`CSTC_ADDR_TDIV);
		chk("divisor reset", rd, 32'h00000FA0);
		rdr(4'hC);
		chk("unmapped read resp", rsp, `CSTC_RESP_ERR);
		chk("unmapped read data", rd, 32'h0);
		wr(4'hC, 32'h1);
		chk("unmapped write resp", rsp, `CSTC_RESP_ERR);
		wr(`CSTC_ADDR_TDIV, 32'h2);
		rdr(`CSTC_ADDR_TDIV);
		chk("divisor", rd, 32'h2);
		chk("off without input", charge_on, 1'b0);
		$display("test registers done");
		ac_on <= 1'b1;
		cyc(6);
		chk("pre running", charge_on, 1'b1);
		fault_after("pre timeout", 3, 15);
		cyc(3);
		chk("off after pre fault", charge_on, 1'b0);
		chk("pull-up below recharge", removal_pullup, 1'b1);
		st("fault state", ST_FAULT);
		present <= 1'b0;
		cyc(10);
		chk("pull-up drops on removal", removal_pullup, 1'b0);
		present <= 1'b1;
		vbat <= 2'h1;
		cyc(10);
		chk("fault cleared below recharge", timer_fault, 1'b0);
		st("fast after pre", ST_FAST);
		fault_after("fast timeout", 90, 140);
		$display("test timeouts done");
		restart(32'h3);
		chk("restart clears fault", timer_fault, 1'b0);
		vbat <= 2'h2;
		fault_after("fast timeout above recharge", 100, 140);
		cyc(6);
		chk("no pull-up above recharge", removal_pullup, 1'b0);
		vbat <= 2'h1;
		cyc(10);
		chk("recover on falling", timer_fault, 1'b0);
		cyc(40);
		misc[3] <= 1'b1;
		cyc(150);
		chk("suspended off", charge_on, 1'b0);
		chk("suspended no fault", timer_fault, 1'b0);
		misc[3] <= 1'b0;
		fault_after("held timer resumes", 50, 100);
		misc[0] <= 1'b1;
		cyc(8);
		chk("lockout clears fault", timer_fault, 1'b0);
		misc[0] <= 1'b0;
		$display("test recovery done");
		misc[4] <= 1'b1;
		vbat <= 2'h2;
		restart(32'h3);
		fault_after("no slowdown above recharge", 100, 140);
		vbat <= 2'h1;
		restart(32'h3);
		fault_after("slowed fast timer", 220, 290);
		vbat <= 2'h0;
		restart(32'h3);
		fault_after("slowed pre timer", 20, 45);
		misc[4] <= 1'b0;
		$display("test slowdown done");
		vbat <= 2'h1;
		restart(32'h7);
		cyc(300);
		chk("fast held by term off", timer_fault, 1'b0);
		st("still fast", ST_FAST);
		misc[1] <= 1'b1;
		vbat <= 2'h0;
		restart(32'h3);
		fault_after("internal timebase", 15000, 17000);
		misc[1] <= 1'b0;
		vbat <= 2'h2;
		misc[2] <= 1'b1;
		restart(32'h3);
		cyc(200);
		chk("terminated no fault", timer_fault, 1'b0);
		st("done state", ST_DONE);
		misc[6:5] <= 2'h3;
		cyc(8);
		rdr(`CSTC_ADDR_STAT);
		chk("loop and supplement", rd[6:5], 2'h3);
		ac_on <= 1'b0;
		cyc(8);
		chk("off with no input", charge_on, 1'b0);
		st("off state", ST_OFF);
		usb_on <= 1'b1;
		cyc(8);
		rdr(`CSTC_ADDR_STAT);
		chk("usb seen", rd[8], 1'b1);
		chk("usb restarts charge", charge_on, 1'b1);
		$display("test modes done");
		give_verdict();
	end
endmodule : tb_charger_safety_timer_control
